// ---- src/crgc_pkg.sv ----
// package of constants and carriers for the codec rate/gain config bank
// assumes a 32-bit apb master on the same clock as the bank
`default_nettype none
package crgc_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] OFS_OSR_VER = 8'h00;
  localparam logic [7:0] OFS_BIAS = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam logic [7:0] OFS_GAIN = 8'h0c;
  localparam logic [7:0] OFS_DAC_GAIN = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int OSR_LSB = 0;
  localparam int VER_LSB = 2;
  localparam int DIV_SEL_BIT = 7;
  localparam int N_LSB = 3;
  localparam int SUB_LSB = 6;
  localparam logic [1:0] OSR_RST = 2'h0;
  localparam logic [5:0] BIAS_RST = 6'h00;
  localparam logic [6:0] M_RST = 7'h00;
  localparam logic [3:0] N_RST = 4'h0;
  localparam logic [2:0] P_RST = 3'h0;
  localparam logic [5:0] GAIN_RST = 6'h00;
  localparam logic [1:0] SUB_ADC = 2'h0;
  localparam logic [1:0] SUB_DAC = 2'h1;
  localparam logic [4:0] GAIN_MUTE = 5'h1f;
  localparam logic [4:0] GAIN_LIN_MAX = 5'h1b;
  localparam logic [9:0] OSR_512 = 10'h200;
  localparam logic [9:0] OSR_256 = 10'h100;
  localparam logic [9:0] OSR_128 = 10'h080;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [6:0] m;
    logic [3:0] n;
    logic [2:0] p;
  } crgc_div_type;
  typedef struct packed {
    logic mute;
    logic [6:0] half_db; // magnitude in 0.5 db units
  } crgc_gain_type;
endpackage
`default_nettype wire

// ---- src/crgc_regs.sv ----
// codec rate/gain configuration bank with apb slave
// assumes apb master on CLOCK_I; mclk-derived rates are computed, not generated
//
// Design decisions made here: the address map and the APB slave port.
`default_nettype none
module crgc_regs #(
  parameter logic [2:0] CHIP_VERSION = 3'h0 // arbitrary value
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output logic [9:0] DAC_OSR_O,
  output logic [5:0] BIAS_DAC_O,
  output logic [7:0] DIV_M_O,
  output logic [4:0] DIV_N_O,
  output logic [3:0] DIV_P_O,
  output logic [18:0] FS_DIVISOR_O,
  output logic [3:0] BCLK_DIVISOR_O,
  output logic [7:0] ADC_GAIN_O,
  output logic [7:0] DAC_ATTEN_O
);
  // ----------------------------------------
  // register map
  // ----------------------------------------
  // byte offsets on the apb side, one word each
  // only the low byte of each word is used
  // upper 24 bits of a read are always zero
  // upper 24 bits of a write are ignored
  //
  // 0x00 oversampling select and version
  //   bits 1..0 oversampling select, read/write
  //   bits 4..2 chip version, read only
  //   bits 7..5 read as zero
  //   a write to bits 4..2 is dropped
  //
  // 0x04 bias dac code
  //   bits 5..0 code fed to the bias dac
  //   bits 7..6 read as zero
  //
  // 0x08 frame divider
  //   write, bit 7 clear: bits 6..3 to n, 2..0 to p
  //   write, bit 7 set: bits 6..0 to m
  //   read returns {0, n code, p code}
  //   m code is read back at 0x18
  //
  // 0x0c shared gain register
  //   bits 7..6 pick the target gain
  //   00 goes to the adc gain code
  //   01 goes to the dac gain code
  //   10 and 11 are dropped silently
  //   read returns the adc code with 00 on top
  //
  // 0x10 dac gain, direct access
  //   bits 5..0 dac gain code
  //   read returns the code with 01 on top
  //
  // 0x14 control
  //   bit 0 fast bit clock mode
  //
  // 0x18 status
  //   bits 6..0 m divider code, read only
  //
  // any other offset raises pslverr
  // writes there change nothing, reads give zero
  // ----------------------------------------
  // timing notes
  // ----------------------------------------
  // pready is tied high: no wait states
  // a write lands on the edge that ends access
  // every derived output moves on that same edge
  // read data is captured in the setup cycle
  // so it stands through the access phase
  // and stays until the next read setup
  // ----------------------------------------
  // decoded outputs
  // ----------------------------------------
  // dividers are shown as values, not codes
  // a zero code stands for the largest value
  // frame divisor is 16*m*n*p, up to 2^18
  // hence the nineteen-bit divisor port
  // bit clock divisor is zero outside fast mode
  // gains carry a mute flag and half-db steps
  // dac attenuation uses the same code table
  // the sign is implied by the port, not stored
  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // zero code means full range
  function automatic logic [7:0] crgc_div_val(input logic [6:0] code, input logic [7:0] full);
    crgc_div_val = (code == 7'h00) ? full : {1'b0, code};
  endfunction

  // gain code to mute flag and half-db magnitude
  function automatic crgc_pkg::crgc_gain_type crgc_gain(input logic [5:0] code);
    crgc_pkg::crgc_gain_type g;
    g.mute = 1'b0;
    g.half_db = 7'h00;
    if (code[4:0] == crgc_pkg::GAIN_MUTE) begin
      g.mute = 1'b1;
    end else if (code[4:0] > crgc_pkg::GAIN_LIN_MAX) begin
      g.half_db = 7'h54 + 7'({code[4:0] - 5'h1c, 2'h0}) + 7'({code[4:0] - 5'h1c, 3'h0});
    end else begin
      g.half_db = 7'(code[4:0]) * 7'h03;
    end
    crgc_gain = g;
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [1:0] osr_reg, osr_next;
  logic [5:0] bias_reg, bias_next;
  crgc_pkg::crgc_div_type div_reg, div_next;
  logic [5:0] adc_gain_reg, adc_gain_next;
  logic [5:0] dac_gain_reg, dac_gain_next;
  logic fast_bclk_reg, fast_bclk_next;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire wr = PSEL_I & PENABLE_I & PWRITE_I;
  wire [7:0] wb = PWDATA_I[7:0];
  wire hit_osr = PADDR_I == crgc_pkg::OFS_OSR_VER;
  wire hit_bias = PADDR_I == crgc_pkg::OFS_BIAS;
  wire hit_div = PADDR_I == crgc_pkg::OFS_DIV;
  wire hit_gain = PADDR_I == crgc_pkg::OFS_GAIN;
  wire hit_dgain = PADDR_I == crgc_pkg::OFS_DAC_GAIN;
  wire hit_ctrl = PADDR_I == crgc_pkg::OFS_CTRL;
  wire hit_stat = PADDR_I == crgc_pkg::OFS_STATUS;
  wire mapped = hit_osr | hit_bias | hit_div | hit_gain | hit_dgain | hit_ctrl | hit_stat;
  wire [1:0] sub_sel = wb[crgc_pkg::SUB_LSB +: 2];
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;

  // next-state for each register
  assign osr_next = (wr && hit_osr) ? wb[crgc_pkg::OSR_LSB +: 2] : osr_reg;
  assign bias_next = (wr && hit_bias) ? wb[5:0] : bias_reg;
  // divider loads m, or n and p together, in one edge
  always_comb begin
    div_next = div_reg;
    if (wr && hit_div) begin
      if (wb[crgc_pkg::DIV_SEL_BIT]) begin
        div_next.m = wb[6:0];
      end else begin
        div_next.n = wb[crgc_pkg::N_LSB +: 4];
        div_next.p = wb[2:0];
      end
    end
  end
  // shared gain routed by top bits
  assign adc_gain_next = (wr && hit_gain && sub_sel == crgc_pkg::SUB_ADC) ? wb[5:0]
                       : adc_gain_reg;
  assign dac_gain_next = (wr && ((hit_gain && sub_sel == crgc_pkg::SUB_DAC) || hit_dgain))
                       ? wb[5:0] : dac_gain_reg;
  assign fast_bclk_next = (wr && hit_ctrl) ? wb[0] : fast_bclk_reg;

  // state update
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      osr_reg <= crgc_pkg::OSR_RST;
      bias_reg <= crgc_pkg::BIAS_RST;
      div_reg <= '{m: crgc_pkg::M_RST, n: crgc_pkg::N_RST, p: crgc_pkg::P_RST};
      adc_gain_reg <= crgc_pkg::GAIN_RST;
      dac_gain_reg <= crgc_pkg::GAIN_RST;
      fast_bclk_reg <= 1'b0;
    end else begin
      osr_reg <= osr_next;
      bias_reg <= bias_next;
      div_reg <= div_next;
      adc_gain_reg <= adc_gain_next;
      dac_gain_reg <= dac_gain_next;
      fast_bclk_reg <= fast_bclk_next;
    end
  end

  // ----------------------------------------
  // derived outputs
  // ----------------------------------------
  // zero-means-max decode
  wire [7:0] m_val = crgc_div_val(div_reg.m, 8'h80);
  wire [7:0] n_val = crgc_div_val({3'h0, div_reg.n}, 8'h10);
  wire [7:0] p_val = crgc_div_val({4'h0, div_reg.p}, 8'h08);
  assign DIV_M_O = m_val;
  assign DIV_N_O = n_val[4:0];
  assign DIV_P_O = p_val[3:0];
  // frame divisor 16*m*n*p
  // product of the three values, at most 2^14
  wire [14:0] frame_divider_values = 15'(m_val) * 15'(n_val[4:0]) * 15'(p_val[3:0]);
  // times sixteen by a plain shift
  assign FS_DIVISOR_O = {frame_divider_values, 4'h0};
  // bit clock divisor, 0 means normal frame-based mode
  assign BCLK_DIVISOR_O = fast_bclk_reg ? p_val[3:0] : 4'h0;
  assign DAC_OSR_O = osr_reg[0] ? crgc_pkg::OSR_512
                   : (osr_reg[1] ? crgc_pkg::OSR_256 : crgc_pkg::OSR_128);
  assign BIAS_DAC_O = bias_reg;
  assign ADC_GAIN_O = crgc_gain(adc_gain_reg);
  assign DAC_ATTEN_O = crgc_gain(dac_gain_reg);

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // version field in bits 4..2
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    // oversampling select with version above it
    if (hit_osr) begin
      rd = {3'h0, CHIP_VERSION, osr_reg};
    end
    // bias code, top bits zero
    if (hit_bias) begin
      rd = {2'h0, bias_reg};
    end
    // n and p codes as written
    if (hit_div) begin
      rd = {1'b0, div_reg.n, div_reg.p};
    end
    // shared gain reads the adc side
    if (hit_gain) begin
      rd = {crgc_pkg::SUB_ADC, adc_gain_reg};
    end
    // direct dac gain with its route bits
    if (hit_dgain) begin
      rd = {crgc_pkg::SUB_DAC, dac_gain_reg};
    end
    // control bits
    if (hit_ctrl) begin
      rd = {7'h00, fast_bclk_reg};
    end
    // m code as written
    if (hit_stat) begin
      rd = {1'b0, div_reg.m};
    end
  end
  // capture in setup so data stands in access
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      PRDATA_O <= {24'h00_0000, rd};
    end
  end
endmodule
`default_nettype wire

// ---- tb/crgc_regs_props.sv ----
// concurrent checks on the config bank ports
// bound into crgc_regs; one clock, sync high reset
`default_nettype none
module crgc_regs_props (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [7:0] DIV_M_O,
  input wire logic [7:0] ADC_GAIN_O,
  input wire logic [31:0] PWDATA_I,
  input wire logic [9:0] DAC_OSR_O,
  input wire logic [5:0] BIAS_DAC_O,
  input wire logic [4:0] DIV_N_O,
  input wire logic [3:0] DIV_P_O,
  input wire logic [18:0] FS_DIVISOR_O
);
  logic w;
  logic [7:0] a, d;
  logic [18:0] fs;
  // completed write, address, low byte, divider product
  assign w = PSEL_I & PENABLE_I & PWRITE_I;
  assign a = PADDR_I;
  assign d = PWDATA_I[7:0];
  assign fs = {DIV_M_O, 4'h0} * DIV_N_O * DIV_P_O;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  property p_osr1; w && a == 8'h00 && d[0] |=> DAC_OSR_O == 10'h200; endproperty
  a_osr1: assert property (p_osr1) else $error("osr not 512");
  property p_osr2;
    w && a == 8'h00 && !d[0] |=> DAC_OSR_O == ($past(d[1]) ? 10'h100 : 10'h080); endproperty
  a_osr2: assert property (p_osr2) else $error("osr not 256 or 128");
  property p_bias; w && a == 8'h04 |=> BIAS_DAC_O == $past(d[5:0]); endproperty
  a_bias: assert property (p_bias) else $error("bias code not loaded");
  property p_m; w && a == 8'h08 && d[7] |=>
    DIV_M_O == {$past(d[6:0]) == 7'h0, $past(d[6:0])} && $stable(DIV_N_O); endproperty
  a_m: assert property (p_m) else $error("m divider wrong");
  property p_np; w && a == 8'h08 && !d[7] |=> {DIV_N_O, DIV_P_O} ==
    {$past(d[6:3]) == 4'h0, $past(d[6:3]), $past(d[2:0]) == 3'h0, $past(d[2:0])}; endproperty
  a_np: assert property (p_np) else $error("n or p divider wrong");
  property p_fs; FS_DIVISOR_O == fs; endproperty
  a_fs: assert property (p_fs) else $error("frame divisor wrong");
  property p_gain; w && a == 8'h0c && d[7:5] == 3'h0 && d[4:0] < 5'h1c |=>
    ADC_GAIN_O == {1'b0, $past(d[4:0]) * 7'h3}; endproperty
  a_gain: assert property (p_gain) else $error("adc gain wrong");
  property p_mute; w && a == 8'h0c && d == 8'h1f |=> ADC_GAIN_O[7]; endproperty
  a_mute: assert property (p_mute) else $error("adc not muted");
  // main scenarios reached
  c_m: cover property (w && a == 8'h08 && d[7]);
  c_mute: cover property (w && a == 8'h0c && d == 8'h1f);
  c_bad: cover property (w && a == 8'h40);
endmodule
bind crgc_regs crgc_regs_props i_props (.*);
`default_nettype wire

// ---- tb/crgc_regs_bench.sv ----
// self-checking apb bench for the config bank
// the bench is the apb master; no partner model
`default_nettype none
module crgc_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLOCK_I = 1'b0, RST_I = 1'b1, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic PREADY_O, PSLVERR_O, serr;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rdat;
  logic [7:0] PADDR_I = 8'h00, DIV_M_O, ADC_GAIN_O, DAC_ATTEN_O;
  logic [9:0] DAC_OSR_O;
  logic [5:0] BIAS_DAC_O;
  logic [4:0] DIV_N_O;
  logic [3:0] DIV_P_O, BCLK_DIVISOR_O;
  logic [18:0] FS_DIVISOR_O;
  logic [7:0] dv [4] = '{8'h81, 8'h7f, 8'h0a, 8'h80};
  logic [16:0] dx [4] = '{17'h308, 17'h2f7, 17'h212, 17'h10012};
  int err_count = 0, tests_run = 0;
  // version strap value is arbitrary
  crgc_regs #(.CHIP_VERSION(3'h5)) i_dut (.*);
  always #50 CLOCK_I = ~CLOCK_I;
  initial #200000 print_verdict(1);
  // compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    err_count += int'(s !== x);
    if (s !== x) $display("mismatch at %0t seen %h exp %h", $time, s, x);
  endtask
  // one apb transfer, held until pready
  task automatic rw(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge CLOCK_I);
    {PSEL_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'b1, wr, a, 24'h0, d};
    @(posedge CLOCK_I);
    PENABLE_I <= 1'b1;
    do @(posedge CLOCK_I); while (PREADY_O !== 1'b1 && ++n < 50);
    if (n >= 50) err_count++;
    {serr, rdat} = {PSLVERR_O, PRDATA_O};
    {PSEL_I, PENABLE_I} <= 2'b00;
    @(negedge CLOCK_I);
  endtask
  // counts, verdict, end of run
  task automatic print_verdict(input int extra);
    err_count += extra;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // expected gain in half-dB, mute flag alone
  function automatic logic [7:0] g(input int c);
    return 8'(c < 28 ? 3 * c : c == 31 ? 128 : 12 * c - 252);
  endfunction
  // test sequence
  initial begin
    repeat (6) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    rw(1'b0, 8'h00, 8'h00);
    chk(rdat, 32'h14);
    chk(32'({DIV_M_O, DIV_N_O, DIV_P_O, BIAS_DAC_O}), 32'h404200);
    chk(32'(FS_DIVISOR_O), 32'h40000);
    chk(32'(DAC_OSR_O), 32'h80);
    for (int i = 0; i < 4; i++) begin
      rw(1'b1, 8'h00, 8'h1c | 8'(i));
      rw(1'b0, 8'h00, 8'h00);
      chk(rdat, 32'h14 | 32'(i));
      chk(32'(DAC_OSR_O), i[0] ? 32'h200 : i[1] ? 32'h100 : 32'h80);
    end
    $display("test osr and version done");
    rw(1'b1, 8'h14, 8'h01);
    rw(1'b0, 8'h14, 8'h00);
    chk(rdat, 32'h1);
    foreach (dx[k]) begin
      rw(1'b1, 8'h08, dv[k]);
      chk(32'({DIV_M_O, DIV_N_O, DIV_P_O}), 32'(dx[k]));
      chk(32'(FS_DIVISOR_O), 32'(16 * dx[k][16:9] * dx[k][8:4] * dx[k][3:0]));
      chk(32'(BCLK_DIVISOR_O), 32'(dx[k][3:0]));
    end
    rw(1'b0, 8'h08, 8'h00);
    chk(rdat, 32'h0a);
    rw(1'b0, 8'h18, 8'h00);
    chk(rdat, 32'h00);
    $display("test dividers done");
    for (int c = 0; c < 32; c++) begin
      rw(1'b1, 8'h0c, 8'(c));
      rw(1'b1, 8'h0c, 8'h40 | 8'(c));
      chk(32'({ADC_GAIN_O, DAC_ATTEN_O} & (c == 31 ? 16'h8080 : 16'hffff)),
          32'({2{g(c)}}));
    end
    rw(1'b1, 8'h10, 8'h05);
    chk(32'(DAC_ATTEN_O), 32'h0f);
    rw(1'b1, 8'h0c, 8'h85);
    chk(32'({ADC_GAIN_O, DAC_ATTEN_O}), 32'h800f);
    rw(1'b1, 8'h04, 8'h2a);
    rw(1'b1, 8'h40, 8'hff);
    chk(32'(serr), 32'h1);
    rw(1'b0, 8'h04, 8'h00);
    chk(rdat, 32'h2a);
    chk(32'(BIAS_DAC_O), 32'h2a);
    rw(1'b0, 8'h40, 8'h00);
    chk(rdat, 32'h0);
    chk(32'(serr), 32'h1);
    $display("test gains, bias and unmapped done");
    print_verdict(0);
  end
endmodule
`default_nettype wire
